// ===== dv/upb_burst_assertions.sv
// Port checks for the burst sequencer
`timescale 1ns/10ps
module upb_burst_chk #(
	parameter int MAX_FRAMES = 8
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Watched ports
	input wire logic CHIP_EN,
	input wire logic START,
	input wire upb_pkg::upb_req_t REQ,
	input wire logic BUSY,
	input wire logic REJECT,
	input wire upb_pkg::upb_tx_t TX
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	a_ctrl_sf_fixed: assert property (TX.ctrl_on |-> TX.ctrl_sf == 9'h100)
		else $error("control sf wrong");
	a_data_sf_k: assert property (TX.data_on |-> TX.data_sf == (9'h100 >> REQ.k))
		else $error("data sf wrong");
	a_parts_parallel: assert property (TX.data_on |-> TX.ctrl_on)
		else $error("data without control");
	a_reject_bad: assert property (START && !BUSY && (REQ.frames == 8'h00
		|| REQ.frames > MAX_FRAMES || REQ.k < 3'h2 || REQ.k > 3'h6) |=> REJECT)
		else $error("bad request not refused");
	a_symbol_step: assert property (TX.preamble && $past(TX.preamble)
		|-> TX.sig_symbol == 4'($past(TX.sig_symbol) + {3'h0, $past(CHIP_EN)}))
		else $error("symbol index skipped");
	a_slot_step: assert property (TX.slot_start && TX.slot != 4'h0
		|-> TX.slot == 4'($past(TX.slot) + 4'h1))
		else $error("slot index skipped");
	a_power_no_tfci: assert property (TX.ctrl_on && !TX.data_on |-> !TX.tfci_on)
		else $error("format field in power preamble");
	a_access_code: assert property (TX.preamble && TX.code != upb_pkg::UPB_CODE_COLL
		|-> TX.signature == REQ.signature && TX.code == (REQ.shared_sigs
		? upb_pkg::UPB_CODE_RANDOM : upb_pkg::UPB_CODE_ACCESS))
		else $error("access preamble code wrong");
	a_coll_code: assert property (TX.preamble && TX.code == upb_pkg::UPB_CODE_COLL
		|-> TX.signature == REQ.coll_signature && $past(TX.preamble))
		else $error("collision preamble wrong");
	a_no_gap: assert property ($fell(TX.preamble) |-> TX.active && TX.ctrl_on)
		else $error("gap after preambles");
endmodule
bind upb_burst upb_burst_chk #(.MAX_FRAMES(MAX_FRAMES)) u_chk (.CLK(CLK), .RST(RST),
	.CHIP_EN(CHIP_EN), .START(START), .REQ(REQ), .BUSY(BUSY), .REJECT(REJECT), .TX(TX));

// ===== dv/upb_burst_bench.sv
// Self-checking bench for the burst sequencer
`timescale 1ns/10ps
`include "upb_regs.svh"
module upb_burst_bench;
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic START = 1'b0;
	logic ACCESS_AGAIN = 1'b1;
	upb_pkg::upb_req_t REQ = '0;
	logic CHIP_EN, FRAME_PAIR, BUSY, REJECT, DONE;
	upb_pkg::upb_tx_t TX;
	int err_count = 0;
	int checked = 0;
	int cyc = 0;
	int fp_cyc = 0;
	logic [31:0] pre_cnt = 32'h0, col_cnt = 32'h0, ctrl_cnt = 32'h0, data_cnt = 32'h0;
	logic [31:0] slot_cnt = 32'h0;
	logic [31:0] notes[$];
	localparam int FRAME = `UPB_SLOTS_PER_FRAME * `UPB_SLOT_CHIPS;
	// Refused cases: frames 0, above the maximum of 2, k below and above range
	logic [10:0] bad[4] = '{{8'h00, 3'h2}, {8'h03, 3'h2}, {8'h01, 3'h1}, {8'h01, 3'h7}};
	upb_far far (.CLK(CLK), .RST(RST), .CHIP_EN(CHIP_EN), .FRAME_PAIR(FRAME_PAIR));
	upb_burst #(.MAX_FRAMES(2)) dut (.CLK(CLK), .RST(RST), .CHIP_EN(CHIP_EN),
		.FRAME_PAIR(FRAME_PAIR), .START(START), .REQ(REQ), .ACCESS_AGAIN(ACCESS_AGAIN),
		.BUSY(BUSY), .REJECT(REJECT), .DONE(DONE), .TX(TX));
	initial forever #12.5 CLK = ~CLK;
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic test_done();
		$display("Checked %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// One-cycle request; REQ fields other than frames and k stay put for the assertions
	task automatic send(input logic [7:0] frames, input logic [2:0] k);
		@(posedge CLK);
		REQ.frames <= frames;
		REQ.k <= k;
		START <= 1'b1;
		@(posedge CLK);
		START <= 1'b0;
		repeat (3) @(posedge CLK);
	endtask
	initial begin
		void'($urandom(32'h4995));
		repeat (20) @(posedge CLK);
		RST <= 1'b0;
		REQ.access_slot <= 4'h1;
		REQ.signature <= 4'($urandom);
		REQ.coll_signature <= 4'($urandom);
		REQ.shared_sigs <= 1'($urandom);
		foreach (bad[i]) begin
			notes.push_back(32'h1);
			send(bad[i][10:3], bad[i][2:0]);
		end
		notes.push_back(32'h2);
		send(8'h01, 3'(2 + $urandom % 5));
		// Bad request while busy must be ignored, so no note is queued
		send(8'h00, REQ.k);
		wait (notes.size() == 0);
		repeat (2) @(posedge CLK);
		test_done();
	end
	// Watcher: counts section chips and pairs each result pulse with the oldest note
	always @(posedge CLK) begin
		cyc++;
		ACCESS_AGAIN <= (pre_cnt < `UPB_PREAMBLE_CHIPS);
		if (cyc > 32'h17ae8) begin
			err_count++;
			test_done();
		end else begin
			// First boundary seen; the slot timer restarts two sync stages later
			if (FRAME_PAIR === 1'b1 && fp_cyc == 0) begin
				fp_cyc = cyc;
			end
			// Slot 1 opens one slot after the boundary, plus sync and output register delay
			if (TX.preamble === 1'b1 && pre_cnt == 32'h0) begin
				chk("start offset", 32'(`UPB_ACCESS_SLOT_CHIPS) + 32'h3, 32'(cyc - fp_cyc));
			end
			pre_cnt += (TX.preamble === 1'b1);
			col_cnt += (TX.preamble === 1'b1 && TX.code === upb_pkg::UPB_CODE_COLL);
			ctrl_cnt += (TX.ctrl_on === 1'b1);
			data_cnt += (TX.data_on === 1'b1);
			slot_cnt += (TX.slot_start === 1'b1);
			if (REJECT === 1'b1 || DONE === 1'b1) begin
				chk("result", notes.size() ? notes.pop_front() : 32'h0, {30'h0, DONE, REJECT});
				if (DONE === 1'b1) begin
					chk("preamble chips", 32'(3 * `UPB_PREAMBLE_CHIPS), pre_cnt);
					chk("collision chips", 32'(`UPB_PREAMBLE_CHIPS), col_cnt);
					chk("control chips", 32'(2 * FRAME), ctrl_cnt);
					chk("data chips", 32'(FRAME), data_cnt);
					// Power preamble and one message frame, 15 slot starts each
					chk("slot starts", 32'(2 * `UPB_SLOTS_PER_FRAME), slot_cnt);
					chk("busy at end", 32'h0, {31'h0, BUSY});
				end
			end
		end
	end
endmodule

// ===== dv/upb_far.sv
// Far-side model: chip strobe and broadcast frame-pair boundary
`timescale 1ns/10ps
module upb_far (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Timing toward the sequencer
	output logic CHIP_EN,
	output logic FRAME_PAIR
);
	logic [5:0] cnt;
	// One boundary edge after reset; the counter stops at 63, so no next edge comes and the level stands
	always_ff @(posedge CLK) begin
		if (RST) begin
			cnt <= 6'h00;
		end else if (cnt != 6'h3f) begin
			cnt <= cnt + 6'h01;
		end
	end
	// Chip rate equals the clock so that a whole burst fits in a short run
	assign CHIP_EN = !RST;
	assign FRAME_PAIR = cnt[5];
endmodule

// ===== hdl/upb_burst.sv
// Uplink packet burst sequencer: preambles, power preamble and message frames
`timescale 1ns/10ps
`include "upb_regs.svh"

// Functional notes
// - Burst opens with one or more access preambles, each 4096 chips.
// - Exactly one collision-check preamble of 4096 chips follows.
// - A 10 ms power-setting preamble in control channel format follows.
// - Message is N whole 10 ms frames, N not above the maximum.
// - Burst starts only at access-slot offsets from broadcast frame boundary.
// - Access-slot timing and structure match the random-access channel.
// - Each message frame has 15 slots of 2560 chips.
// - Data and control parts of a slot are sent in parallel.
// - Data part holds 10*2^k bits, k 2..6, spreading factor 64 down to 4.
// - Control part always uses spreading factor 256.
// - Power preamble control fields carry pilot and power bits, no format field.
// - Collision preamble uses random-access signatures with its own scrambling segment.
// - Access preambles use a signature subset; own segment or shared random-access code.
// - Fifteen start offsets per two broadcast frames, spaced 5120 chips.
// - Each preamble is a 16-symbol signature repeated 256 times.
// - Signature is one of 16 Hadamard-derived signatures.
module upb_burst #(
	parameter int MAX_FRAMES = 8
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Chip strobe and broadcast frame boundary (every second frame)
	input wire logic CHIP_EN,
	input wire logic FRAME_PAIR,
	// Burst request
	input wire logic START,
	input wire upb_pkg::upb_req_t REQ,
	input wire logic ACCESS_AGAIN,
	output logic BUSY,
	output logic REJECT,
	output logic DONE,
	// Transmit control
	output upb_pkg::upb_tx_t TX
);
	upb_pkg::upb_st_t s;
	upb_pkg::upb_st_t next_s;
	logic frame_pair_m;
	logic frame_pair_q;
	logic frame_pair_d;
	logic frame_edge;

	// Valid k maps to data spreading factor 64 >> (k - 2)
	function automatic logic [8:0] data_sf(input logic [2:0] k);
		data_sf = 9'(`UPB_SF_AT_KMIN >> (k - `UPB_K_MIN));
	endfunction

	// Boundary pin is asynchronous to the chip clock, so resync before edge detect
	always_ff @(posedge CLK) begin
		if (RST) begin
			frame_pair_m <= 1'b0;
			frame_pair_q <= 1'b0;
			frame_pair_d <= 1'b0;
		end else begin
			frame_pair_m <= FRAME_PAIR;
			frame_pair_q <= frame_pair_m;
			frame_pair_d <= frame_pair_q;
		end
	end
	assign frame_edge = frame_pair_q & ~frame_pair_d;

	// Sequencer and access-slot timer
	always_comb begin
		logic seg_end;
		logic slot_end;
		next_s = s;
		seg_end = 1'b0;
		slot_end = 1'b0;
		next_s.rejected = 1'b0;
		next_s.done = 1'b0;
		next_s.tx.slot_start = 1'b0;
		// Access slots restart on the frame-pair boundary
		if (frame_edge) begin
			next_s.as_chip = 14'h0000;
			next_s.as_num = 4'h0;
			next_s.frame_seen = 1'b1;
		end else if (CHIP_EN) begin
			if (s.as_chip == `UPB_ACCESS_SLOT_CHIPS - 14'h0001) begin
				next_s.as_chip = 14'h0000;
				if (s.as_num != `UPB_ACCESS_SLOTS - 4'h1) begin
					next_s.as_num = s.as_num + 4'h1;
				end
			end else begin
				next_s.as_chip = s.as_chip + 14'h0001;
			end
		end
		// Segment chips: access and collision preambles are 16 symbols repeated 256 times per 4096 chips; power and message parts run 2560-chip slots
		if (CHIP_EN && s.state != upb_pkg::UPB_IDLE && s.state != upb_pkg::UPB_WAIT) begin
			next_s.chip_ctr = s.chip_ctr + 14'h0001;
			if (s.chip_ctr[3:0] == 4'hf) begin
				next_s.rep_ctr = s.rep_ctr + 9'h001;
			end
			if (s.state == upb_pkg::UPB_ACCESS || s.state == upb_pkg::UPB_COLL) begin
				// Preamble ends on the last symbol of the last signature repetition
				seg_end = (s.chip_ctr == `UPB_PREAMBLE_CHIPS - 14'h0001) &&
					(s.rep_ctr == `UPB_SIG_REPEATS - 9'h001);
			end else begin
				slot_end = (s.chip_ctr == `UPB_SLOT_CHIPS - 14'h0001);
				seg_end = slot_end && (s.slot_ctr == `UPB_SLOTS_PER_FRAME - 4'h1);
			end
			if (seg_end || slot_end) begin
				next_s.chip_ctr = 14'h0000;
				next_s.rep_ctr = 9'h000;
			end
			if (slot_end) begin
				next_s.slot_ctr = seg_end ? 4'h0 : s.slot_ctr + 4'h1;
				next_s.tx.slot_start = 1'b1;
				next_s.tx.slot = seg_end ? 4'h0 : s.slot_ctr + 4'h1;
			end
		end
		case (s.state)
			upb_pkg::UPB_IDLE: begin
				if (START) begin
					// Over-long message or out-of-range k is refused outright
					if (REQ.frames == 8'h00 || 32'(REQ.frames) > MAX_FRAMES ||
						REQ.k < `UPB_K_MIN || REQ.k > `UPB_K_MAX) begin
						next_s.rejected = 1'b1;
					end else begin
						next_s.req = REQ;
						next_s.state = upb_pkg::UPB_WAIT;
					end
				end
			end
			upb_pkg::UPB_WAIT: begin
				// Start only on an access-slot boundary matching the requested slot
				if (CHIP_EN && s.frame_seen && s.as_chip == `UPB_ACCESS_SLOT_CHIPS - 14'h0001 &&
					(s.as_num == `UPB_ACCESS_SLOTS - 4'h1 ? 4'h0 : s.as_num + 4'h1) ==
					s.req.access_slot) begin
					next_s.state = upb_pkg::UPB_ACCESS;
					next_s.chip_ctr = 14'h0000;
					next_s.rep_ctr = 9'h000;
					next_s.slot_ctr = 4'h0;
				end
			end
			upb_pkg::UPB_ACCESS: begin
				// ACCESS_AGAIN sampled at preamble end repeats the access preamble
				if (seg_end && !ACCESS_AGAIN) begin
					next_s.state = upb_pkg::UPB_COLL;
				end
			end
			upb_pkg::UPB_COLL: begin
				if (seg_end) begin
					next_s.state = upb_pkg::UPB_POWER;
					next_s.tx.slot_start = 1'b1;
					next_s.tx.slot = 4'h0;
				end
			end
			upb_pkg::UPB_POWER: begin
				if (seg_end) begin
					next_s.state = upb_pkg::UPB_MSG;
					next_s.frame_ctr = 8'h00;
					next_s.tx.slot_start = 1'b1;
				end
			end
			upb_pkg::UPB_MSG: begin
				if (seg_end) begin
					if (s.frame_ctr == s.req.frames - 8'h01) begin
						next_s.state = upb_pkg::UPB_IDLE;
						next_s.done = 1'b1;
						next_s.tx.slot_start = 1'b0;
					end else begin
						next_s.frame_ctr = s.frame_ctr + 8'h01;
					end
				end
			end
			default: begin
				next_s.state = upb_pkg::UPB_IDLE;
			end
		endcase
		// Transmit control follows the state being entered
		next_s.tx.active = 1'b0;
		next_s.tx.preamble = 1'b0;
		next_s.tx.code = upb_pkg::UPB_CODE_NONE;
		next_s.tx.data_on = 1'b0;
		next_s.tx.ctrl_on = 1'b0;
		next_s.tx.tfci_on = 1'b0;
		next_s.tx.signature = 4'h0;
		next_s.tx.sig_symbol = 4'h0;
		next_s.tx.data_sf = data_sf(next_s.req.k);
		next_s.tx.ctrl_sf = `UPB_CTRL_SF;
		case (next_s.state)
			upb_pkg::UPB_ACCESS: begin
				next_s.tx.active = 1'b1;
				next_s.tx.preamble = 1'b1;
				next_s.tx.signature = next_s.req.signature;
				// Symbol index tracks the chip now going out, not the one before it
				next_s.tx.sig_symbol = next_s.chip_ctr[3:0];
				next_s.tx.code = next_s.req.shared_sigs ? upb_pkg::UPB_CODE_RANDOM :
					upb_pkg::UPB_CODE_ACCESS;
			end
			upb_pkg::UPB_COLL: begin
				next_s.tx.active = 1'b1;
				next_s.tx.preamble = 1'b1;
				next_s.tx.signature = next_s.req.coll_signature;
				next_s.tx.sig_symbol = next_s.chip_ctr[3:0];
				next_s.tx.code = upb_pkg::UPB_CODE_COLL;
			end
			upb_pkg::UPB_POWER: begin
				next_s.tx.active = 1'b1;
				next_s.tx.ctrl_on = 1'b1;
			end
			upb_pkg::UPB_MSG: begin
				next_s.tx.active = 1'b1;
				next_s.tx.data_on = 1'b1;
				next_s.tx.ctrl_on = 1'b1;
				next_s.tx.tfci_on = 1'b1;
			end
			default: begin
				next_s.tx.sig_symbol = 4'h0;
			end
		endcase
	end

	// State register
	always_ff @(posedge CLK) begin
		if (RST) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign BUSY = (s.state != upb_pkg::UPB_IDLE);
	assign REJECT = s.rejected;
	assign DONE = s.done;
	assign TX = s.tx;
endmodule

// ===== hdl/upb_pkg.sv
// Types for the uplink packet burst sequencer
package upb_pkg;
	typedef enum logic [2:0] {
		UPB_IDLE = 3'b000,
		UPB_WAIT = 3'b001,
		UPB_ACCESS = 3'b010,
		UPB_COLL = 3'b011,
		UPB_POWER = 3'b100,
		UPB_MSG = 3'b101
	} upb_state_t;

	typedef enum logic [1:0] {
		UPB_CODE_NONE = 2'b00,
		UPB_CODE_ACCESS = 2'b01,
		UPB_CODE_RANDOM = 2'b10,
		UPB_CODE_COLL = 2'b11
	} upb_code_t;

	// Burst request from the access controller
	typedef struct packed {
		logic [3:0] access_slot;
		logic [3:0] signature;
		logic [3:0] coll_signature;
		logic [7:0] frames;
		logic [2:0] k;
		logic shared_sigs;
	} upb_req_t;

	// Per-chip transmit control toward the modulator
	typedef struct packed {
		logic active;
		logic preamble;
		logic [3:0] signature;
		logic [3:0] sig_symbol;
		upb_code_t code;
		logic data_on;
		logic ctrl_on;
		logic tfci_on;
		logic [8:0] data_sf;
		logic [8:0] ctrl_sf;
		logic [3:0] slot;
		logic slot_start;
	} upb_tx_t;

	typedef struct packed {
		upb_state_t state;
		upb_req_t req;
		logic [3:0] slot_ctr;
		logic [13:0] chip_ctr;
		logic [8:0] rep_ctr;
		logic [7:0] frame_ctr;
		logic [3:0] slot;
		logic [13:0] as_chip;
		logic [3:0] as_num;
		logic frame_seen;
		logic rejected;
		logic done;
		upb_tx_t tx;
	} upb_st_t;
endpackage

// ===== hdl/upb_regs.svh
// Timing constants for the uplink packet burst sequencer
`ifndef UPB_REGS_SVH
`define UPB_REGS_SVH
`define UPB_PREAMBLE_CHIPS 14'h1000
`define UPB_SLOT_CHIPS 14'h0a00
`define UPB_SLOTS_PER_FRAME 4'hf
`define UPB_ACCESS_SLOT_CHIPS 14'h1400
`define UPB_ACCESS_SLOTS 4'hf
`define UPB_SIG_REPEATS 9'h100
`define UPB_SIG_SYMBOLS 5'h10
`define UPB_CTRL_SF 9'h100
`define UPB_K_MIN 3'h2
`define UPB_K_MAX 3'h6
`define UPB_SF_AT_KMIN 9'h040
`endif
